//--- rtl/sagc_chan_decode.sv
// Decoder of one channel's noise gate and clip control byte
`default_nettype none
`include "sagc_consts.svh"
module sagc_chan_decode
   import sagc_pkg::*;
(
   input  wire logic [7:0]     ctrl,  // Channel control byte C
   output sagc_chan_cfg_t      cfg    // Decoded settings
);
   logic [1:0] hyst_code;
   logic [4:0] thr_code;

   // =====================================================================
   // Field extraction
   assign hyst_code = ctrl[`SAGC_HYST_HI:`SAGC_HYST_LO];
   assign thr_code  = ctrl[`SAGC_THR_HI:`SAGC_THR_LO];

   // Hysteresis, threshold and clip decode
   always_comb begin
      cfg.hyst_en = (hyst_code != `SAGC_HYST_OFF);
      unique case (hyst_code)
         2'h0:    cfg.hyst_db = `SAGC_HYST_1DB;
         2'h1:    cfg.hyst_db = `SAGC_HYST_2DB;
         2'h2:    cfg.hyst_db = `SAGC_HYST_4DB;
         2'h3:    cfg.hyst_db = 3'h0;
      endcase
      cfg.det_en    = (thr_code != `SAGC_THR_OFF);
      cfg.thresh_db = cfg.det_en ?
                      `SAGC_THR_BASE_DB + 7'({thr_code, 1'b0}) : 7'h00;
      cfg.clip_en   = ctrl[`SAGC_CLIP_BIT];
   end
endmodule // sagc_chan_decode
`default_nettype wire

//--- rtl/sagc_consts.svh
// Register indices, field positions, reset values and code tables of the record gain control bank
`ifndef SAGC_CONSTS_SVH
`define SAGC_CONSTS_SVH
// =====================================================================
// Register indices (byte address = index * 4)
`define SAGC_IDX_LEFT_C      8'h1c
`define SAGC_IDX_RIGHT_A     8'h1d
`define SAGC_IDX_RIGHT_B     8'h1e
`define SAGC_IDX_RIGHT_C     8'h1f
`define SAGC_IDX_LEFT_GAIN   8'h20
`define SAGC_IDX_LSB         2
// =====================================================================
// Reset values
`define SAGC_RST_LEFT_C      8'h00
`define SAGC_RST_RIGHT_A     8'h00
`define SAGC_RST_RIGHT_B     7'h7f
`define SAGC_RST_RIGHT_C     8'h00
`define SAGC_RST_GAIN        8'h00
// =====================================================================
// Field positions
`define SAGC_HYST_HI         7
`define SAGC_HYST_LO         6
`define SAGC_THR_HI          5
`define SAGC_THR_LO          1
`define SAGC_CLIP_BIT        0
`define SAGC_EN_BIT          7
`define SAGC_TGT_HI          6
`define SAGC_TGT_LO          4
`define SAGC_ATK_HI          3
`define SAGC_ATK_LO          2
`define SAGC_DCY_HI          1
`define SAGC_DCY_LO          0
`define SAGC_MAXG_HI         7
`define SAGC_MAXG_LO         1
// =====================================================================
// Hysteresis codes and levels in dB
`define SAGC_HYST_OFF        2'h3
`define SAGC_HYST_1DB        3'h1
`define SAGC_HYST_2DB        3'h2
`define SAGC_HYST_4DB        3'h4
// Noise threshold: magnitude dB = base + step * code, code 0 disables
`define SAGC_THR_OFF         5'h00
`define SAGC_THR_BASE_DB     7'h1c
`define SAGC_THR_STEP_SH     1
// Target magnitude in 0.5 dB units: 5.5 8 10 12 14 17 20 24 dB
`define SAGC_TGT_0           6'h0b
`define SAGC_TGT_1           6'h10
`define SAGC_TGT_2           6'h14
`define SAGC_TGT_3           6'h18
`define SAGC_TGT_4           6'h1c
`define SAGC_TGT_5           6'h22
`define SAGC_TGT_6           6'h28
`define SAGC_TGT_7           6'h30
// Attack times in ms
`define SAGC_ATK_0           5'h08
`define SAGC_ATK_1           5'h0b
`define SAGC_ATK_2           5'h10
`define SAGC_ATK_3           5'h14
// Decay times in ms
`define SAGC_DCY_0           9'h064
`define SAGC_DCY_1           9'h0c8
`define SAGC_DCY_2           9'h190
`define SAGC_DCY_3           9'h1f4
// Maximum gain ceiling code, 59.5 dB in 0.5 dB steps
`define SAGC_MAXG_CEIL       7'h77
`endif

//--- rtl/sagc_pkg.sv
// Types shared by the record gain control register bank
`default_nettype none
package sagc_pkg;
   // Decoded noise gate and clip settings of one channel
   typedef struct packed {
      logic       hyst_en;
      logic [2:0] hyst_db;
      logic       det_en;
      logic [6:0] thresh_db;
      logic       clip_en;
   } sagc_chan_cfg_t;

   // Decoded right channel loop settings
   typedef struct packed {
      logic       enable;
      logic [5:0] target_hdb;
      logic [4:0] attack_ms;
      logic [8:0] decay_ms;
      logic [6:0] max_gain_hdb;
      logic       times_exact;
   } sagc_loop_cfg_t;

   // APB answer
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } sagc_apb_rsp_t;
endpackage
`default_nettype wire

//--- rtl/sagc_regs.sv
// Record gain control register bank: APB slave, decoded settings, left applied-gain readout
// Functional notes
// - Hysteresis codes 00/01/10 give 1/2/4 dB; code 11 disables hysteresis.
// - Left threshold code zero disables left noise and silence detection.
// - Threshold code 1 is -30 dB, each step 2 dB lower, to -90 dB.
// - Left control C bit 0 enables left clip stepping.
// - Right control A bit 7 enables right gain control; resets off.
// - Right target codes select -5.5,-8,-10,-12,-14,-17,-20,-24 dB.
// - Right attack codes select 8, 11, 16, 20 ms.
// - Right decay codes select 100, 200, 400, 500 ms.
// - Listed times hold only without double-rate operation.
// - Right maximum gain in 0.5 dB steps, 0.0 to 59.5 dB.
// - Maximum-gain codes 1110111 and above limit gain to 59.5 dB.
// - Right control C bit 0 enables right clip stepping.
// - Right threshold code zero disables right detection; same table as left.
// - Left applied gain is a read-only byte, reset zero.
// - Applied gain is two's complement in 0.5 dB, -12.0 to +59.5 dB.
//
// Register access over APB was decided locally.
`default_nettype none
`include "sagc_consts.svh"
module sagc_regs
   import sagc_pkg::*;
#(
   parameter int ADDR_W = 12                      // APB address width
) (
   input  wire logic              ref_clk,        // Core clock, 20 MHz
   input  wire logic              rst,            // Synchronous reset, active high
   input  wire logic              ce,             // Clock enable, freezes all state when low
   // APB slave
   input  wire logic              psel,           // Slave select
   input  wire logic              penable,        // Access phase
   input  wire logic              pwrite,         // Write direction
   input  wire logic [ADDR_W-1:0] paddr,          // Byte address
   input  wire logic [31:0]       pwdata,         // Write data
   input  wire logic [3:0]        pstrb,          // Byte strobes
   output logic                   pready,         // Transfer done
   output logic                   pslverr,        // Unmapped address
   output logic [31:0]            prdata,         // Read data
   // Gain loop side
   input  wire logic              double_rate,    // Double-rate audio active
   input  wire logic [6:0]        left_max_code,  // Left maximum-gain code from its own register
   input  wire logic              loop_gain_upd,  // Left loop updated its gain, pulse
   input  wire logic [7:0]        loop_gain,      // Left loop live gain, two's complement 0.5 dB
   // Decoded settings
   output sagc_chan_cfg_t         left_gate,      // Left noise gate and clip settings
   output sagc_chan_cfg_t         right_gate,     // Right noise gate and clip settings
   output sagc_loop_cfg_t         right_loop,     // Right loop settings
   output logic [7:0]             left_gain       // Left applied gain, as read back
);
   // =====================================================================
   // State
   typedef struct packed {
      logic [7:0]      left_c;
      logic [7:0]      right_a;
      logic [6:0]      right_b;
      logic [7:0]      right_c;
      logic [7:0]      gain;
      sagc_chan_cfg_t  lgate;
      sagc_chan_cfg_t  rgate;
      sagc_loop_cfg_t  rloop;
      sagc_apb_rsp_t   rsp;
   } sagc_state_t;

   sagc_state_t     state_reg;
   sagc_state_t     state_next;
   sagc_chan_cfg_t  gate_dec [2];
   logic [7:0]      ctrl_c   [2];
   logic [7:0]      idx;
   logic            aligned;
   logic            hit_lc;
   logic            hit_ra;
   logic            hit_rb;
   logic            hit_rc;
   logic            hit_gain;
   logic            mapped;
   logic            setup;
   logic            commit;
   logic [7:0]      wbyte;
   logic [7:0]      rbyte;
   logic [7:0]      lim_left;

   // =====================================================================
   // Address decode
   assign idx      = 8'(paddr >> `SAGC_IDX_LSB);
   assign aligned  = (paddr[`SAGC_IDX_LSB-1:0] == 2'h0) && ((paddr >> `SAGC_IDX_LSB) == ADDR_W'(idx));
   assign hit_lc   = aligned && (idx == `SAGC_IDX_LEFT_C);
   assign hit_ra   = aligned && (idx == `SAGC_IDX_RIGHT_A);
   assign hit_rb   = aligned && (idx == `SAGC_IDX_RIGHT_B);
   assign hit_rc   = aligned && (idx == `SAGC_IDX_RIGHT_C);
   assign hit_gain = aligned && (idx == `SAGC_IDX_LEFT_GAIN);
   assign mapped   = hit_lc | hit_ra | hit_rb | hit_rc | hit_gain;

   // Setup cycle and access completion
   assign setup  = psel && !penable;
   assign commit = psel && penable && state_reg.rsp.pready;
   assign wbyte  = pwdata[7:0];

   // =====================================================================
   // Per-channel gate decode, left then right
   assign ctrl_c[0] = (commit && pwrite && pstrb[0] && hit_lc) ? wbyte : state_reg.left_c;
   assign ctrl_c[1] = (commit && pwrite && pstrb[0] && hit_rc) ? wbyte : state_reg.right_c;

   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_chan
         sagc_chan_decode u_dec (
            .ctrl (ctrl_c[ch]),
            .cfg  (gate_dec[ch])
         );
      end
   endgenerate

   // =====================================================================
   // Read mux
   always_comb begin
      rbyte = 8'h00;
      if (hit_lc)   rbyte = state_reg.left_c;
      if (hit_ra)   rbyte = state_reg.right_a;
      if (hit_rb)   rbyte = {state_reg.right_b, 1'b0};                       // Reserved bit reads zero
      if (hit_rc)   rbyte = state_reg.right_c;
      if (hit_gain) rbyte = state_reg.gain;
   end

   // Left gain ceiling, codes at or above the top saturate
   assign lim_left = {1'b0, (left_max_code > `SAGC_MAXG_CEIL) ? `SAGC_MAXG_CEIL : left_max_code};

   // Clamp a signed loop gain to the left ceiling
   function automatic logic [7:0] sagc_clamp(input logic [7:0] g, input logic [7:0] lim);
      logic [7:0] r;
      r = ($signed(g) > $signed(lim)) ? lim : g;
      return r;
   endfunction

   // =====================================================================
   // Next-state logic
   always_comb begin
      state_next = state_reg;

      // APB answer: ready one cycle after setup, dropped after completion
      if (commit) begin
         state_next.rsp.pready  = 1'b0;
         state_next.rsp.pslverr = 1'b0;
         state_next.rsp.prdata  = 32'h0000_0000;
      end else if (setup) begin
         state_next.rsp.pready  = 1'b1;
         state_next.rsp.pslverr = !mapped;
         state_next.rsp.prdata  = (!pwrite && mapped) ? {24'h00_0000, rbyte} : 32'h0000_0000;
      end

      // Register writes take effect at completion, low lane strobed
      if (commit && pwrite && pstrb[0]) begin
         if (hit_lc) state_next.left_c  = wbyte;
         if (hit_ra) state_next.right_a = wbyte;
         if (hit_rb) state_next.right_b = wbyte[`SAGC_MAXG_HI:`SAGC_MAXG_LO];
         if (hit_rc) state_next.right_c = wbyte;
      end

      // Applied-gain readout follows the loop, held under the ceiling
      if (loop_gain_upd)
         state_next.gain = sagc_clamp(loop_gain, lim_left);
      else
         state_next.gain = sagc_clamp(state_reg.gain, lim_left);

      // Decoded gate settings
      state_next.lgate = gate_dec[0];
      state_next.rgate = gate_dec[1];

      // Right loop settings
      state_next.rloop.enable = state_next.right_a[`SAGC_EN_BIT];
      unique case (state_next.right_a[`SAGC_TGT_HI:`SAGC_TGT_LO])
         3'h0:    state_next.rloop.target_hdb = `SAGC_TGT_0;
         3'h1:    state_next.rloop.target_hdb = `SAGC_TGT_1;
         3'h2:    state_next.rloop.target_hdb = `SAGC_TGT_2;
         3'h3:    state_next.rloop.target_hdb = `SAGC_TGT_3;
         3'h4:    state_next.rloop.target_hdb = `SAGC_TGT_4;
         3'h5:    state_next.rloop.target_hdb = `SAGC_TGT_5;
         3'h6:    state_next.rloop.target_hdb = `SAGC_TGT_6;
         3'h7:    state_next.rloop.target_hdb = `SAGC_TGT_7;
      endcase
      unique case (state_next.right_a[`SAGC_ATK_HI:`SAGC_ATK_LO])
         2'h0:    state_next.rloop.attack_ms = `SAGC_ATK_0;
         2'h1:    state_next.rloop.attack_ms = `SAGC_ATK_1;
         2'h2:    state_next.rloop.attack_ms = `SAGC_ATK_2;
         2'h3:    state_next.rloop.attack_ms = `SAGC_ATK_3;
      endcase
      unique case (state_next.right_a[`SAGC_DCY_HI:`SAGC_DCY_LO])
         2'h0:    state_next.rloop.decay_ms = `SAGC_DCY_0;
         2'h1:    state_next.rloop.decay_ms = `SAGC_DCY_1;
         2'h2:    state_next.rloop.decay_ms = `SAGC_DCY_2;
         2'h3:    state_next.rloop.decay_ms = `SAGC_DCY_3;
      endcase
      state_next.rloop.max_gain_hdb = (state_next.right_b > `SAGC_MAXG_CEIL) ?
                                      `SAGC_MAXG_CEIL : state_next.right_b;
      state_next.rloop.times_exact  = !double_rate;
   end

   // =====================================================================
   // State register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg                    <= '0;
         state_reg.left_c             <= `SAGC_RST_LEFT_C;
         state_reg.right_a            <= `SAGC_RST_RIGHT_A;
         state_reg.right_b            <= `SAGC_RST_RIGHT_B;
         state_reg.right_c            <= `SAGC_RST_RIGHT_C;
         state_reg.gain               <= `SAGC_RST_GAIN;
         state_reg.lgate.hyst_en      <= 1'b1;
         state_reg.lgate.hyst_db      <= `SAGC_HYST_1DB;
         state_reg.rgate.hyst_en      <= 1'b1;
         state_reg.rgate.hyst_db      <= `SAGC_HYST_1DB;
         state_reg.rloop.target_hdb   <= `SAGC_TGT_0;
         state_reg.rloop.attack_ms    <= `SAGC_ATK_0;
         state_reg.rloop.decay_ms     <= `SAGC_DCY_0;
         state_reg.rloop.max_gain_hdb <= `SAGC_MAXG_CEIL;
         state_reg.rloop.times_exact  <= 1'b1;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // =====================================================================
   // Outputs straight from the state register
   assign pready     = state_reg.rsp.pready;
   assign pslverr    = state_reg.rsp.pslverr;
   assign prdata     = state_reg.rsp.prdata;
   assign left_gate  = state_reg.lgate;
   assign right_gate = state_reg.rgate;
   assign right_loop = state_reg.rloop;
   assign left_gain  = state_reg.gain;
endmodule // sagc_regs
`default_nettype wire

//--- testbench/sagc_regs_chk.sv
// Concurrent checks on the ports of the record gain control register bank
`default_nettype none
module sagc_regs_chk
   import sagc_pkg::*;
(
   input wire logic           ref_clk,        // Core clock
   input wire logic           rst,            // Synchronous reset
   input wire logic           ce,             // Clock enable
   input wire logic           psel,           // Slave select
   input wire logic           penable,        // Access phase
   input wire logic           pready,         // Transfer done
   input wire logic           pslverr,        // Error answer
   input wire logic [31:0]    prdata,         // Read data
   input wire logic           double_rate,    // Double-rate mode
   input wire logic [6:0]     left_max_code,  // Left maximum-gain code
   input wire logic           loop_gain_upd,  // Gain update pulse
   input wire logic [7:0]     loop_gain,      // Live loop gain
   input wire sagc_chan_cfg_t left_gate,      // Left gate settings
   input wire sagc_loop_cfg_t right_loop,     // Right loop settings
   input wire logic [7:0]     left_gain       // Applied gain readout
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================================================
   // Readout ceiling from the left maximum-gain code
   logic [6:0] lim;
   assign lim = (left_max_code > 7'h77) ? 7'h77 : left_max_code;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // =====================================================================
   // Bus handshake and read data
   a_ready_next: assert property (psel && !penable && ce |=> pready)
      else $error("no answer after setup");
   a_ready_single: assert property (pready && ce |=> !pready)
      else $error("answer held too long");
   a_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   a_err_nodata: assert property (pready && pslverr |-> prdata == 32'h00000000)
      else $error("data on error answer");
   // =====================================================================
   // Decoded settings
   a_hyst_table: assert property (left_gate.hyst_en ? (left_gate.hyst_db inside {3'h1, 3'h2, 3'h4})
      : (left_gate.hyst_db == 3'h0)) else $error("hysteresis level wrong");
   a_thr_range: assert property (left_gate.det_en ? (left_gate.thresh_db inside {[7'h1e:7'h5a]}
      && !left_gate.thresh_db[0]) : (left_gate.thresh_db == 7'h00)) else $error("threshold wrong");
   a_time_codes: assert property (right_loop.attack_ms inside {5'h08, 5'h0b, 5'h10, 5'h14}
      && right_loop.decay_ms inside {9'h064, 9'h0c8, 9'h190, 9'h1f4}) else $error("time code wrong");
   a_maxg_clamp: assert property (right_loop.max_gain_hdb <= 7'h77)
      else $error("maximum gain above ceiling");
   a_exact_rate: assert property ($past(ce) && !$past(rst) |-> right_loop.times_exact == !$past(double_rate))
      else $error("exact-time flag wrong");
   // =====================================================================
   // Applied gain readout
   a_gain_ceil: assert property ($past(ce) |-> $signed(left_gain) <= $signed({1'b0, $past(lim)}))
      else $error("gain above maximum");
   a_gain_track: assert property (ce && loop_gain_upd && $signed(loop_gain) <= $signed({1'b0, lim})
      |=> left_gain == $past(loop_gain)) else $error("gain not tracked");
endmodule // sagc_regs_chk

bind sagc_regs sagc_regs_chk i_sagc_regs_chk (.ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .double_rate(double_rate),
   .left_max_code(left_max_code), .loop_gain_upd(loop_gain_upd), .loop_gain(loop_gain),
   .left_gate(left_gate), .right_loop(right_loop), .left_gain(left_gain));
`default_nettype wire

//--- testbench/sagc_regs_tb.sv
// Self-checking bench of the record gain control register bank
`default_nettype none
module sagc_regs_tb
   import sagc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================================================
   // Stimulus, answers and tables
   logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic loop_gain_upd = 1'b0, double_rate = 1'b0, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  pstrb = 4'hf;
   logic [6:0]  left_max_code = 7'h7f, c;
   logic [7:0]  loop_gain = 8'h00, left_gain, d;
   logic [1:0]  h;
   logic [4:0]  t;
   sagc_chan_cfg_t left_gate, right_gate, g;
   sagc_loop_cfg_t right_loop;
   int miscompares = 0, num_checks = 0, cyc = 0;
   logic [11:0] adr [5] = '{12'h070, 12'h074, 12'h078, 12'h07c, 12'h080};  // Index times four
   logic [7:0]  rstv [5] = '{8'h00, 8'h00, 8'hfe, 8'h00, 8'h00};
   logic [4:0]  thr [8] = '{5'h00, 5'h01, 5'h02, 5'h1f, 5'h10, 5'h1e, 5'h03, 5'h00};
   logic [5:0]  tgt [8] = '{6'h0b, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h22, 6'h28, 6'h30};
   logic [4:0]  atk [4] = '{5'h08, 5'h0b, 5'h10, 5'h14};
   logic [8:0]  dcy [4] = '{9'h064, 9'h0c8, 9'h190, 9'h1f4};
   logic [6:0]  mg [5] = '{7'h00, 7'h01, 7'h76, 7'h77, 7'h7f};
   logic [7:0]  gin [3] = '{8'he8, 8'h05, 8'h77};
   logic [7:0]  gex [3] = '{8'he8, 8'h05, 8'h10};

   sagc_regs i_sagc_regs (.ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .double_rate(double_rate), .left_max_code(left_max_code), .loop_gain_upd(loop_gain_upd),
      .loop_gain(loop_gain), .left_gate(left_gate), .right_gate(right_gate), .right_loop(right_loop),
      .left_gain(left_gain));

   // Clock, 50 ns period
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   // =====================================================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] dv);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, dv};
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse(input logic [7:0] gv);
      @(posedge ref_clk);
      loop_gain_upd <= 1'b1;
      loop_gain <= gv;
      @(posedge ref_clk);
      loop_gain_upd <= 1'b0;
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         give_verdict();
      end
   end
   // =====================================================================
   // Test sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, adr[i], 8'h00);
         chk(rd, {24'h0, rstv[i]});
      end
      chk(32'(right_loop.enable), 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 16; i++) begin
         h = 2'(i);
         t = thr[i % 8];
         d = {h, t, 1'(i / 4)};
         apb(1'b1, (i >= 8) ? adr[3] : adr[0], d);
         apb(1'b0, (i >= 8) ? adr[3] : adr[0], 8'h00);
         chk(rd, {24'h0, d});
         g = (i >= 8) ? right_gate : left_gate;
         chk(32'(g.hyst_en), 32'(h != 2'h3));
         chk(32'(g.hyst_db), (h == 2'h3) ? 32'h0 : 32'h1 << h);
         chk(32'(g.det_en), 32'(t != 5'h00));
         chk(32'(g.thresh_db), (t == 5'h00) ? 32'h0 : 32'h1c + 32'(t) * 2);
         chk(32'(g.clip_en), 32'(d[0]));
      end
      $display("test noise gate done");
      for (int i = 0; i < 8; i++) begin
         d = {1'(i), 3'(i), 2'(i), ~2'(i)};
         apb(1'b1, adr[1], d);
         apb(1'b0, adr[1], 8'h00);
         chk(rd, {24'h0, d});
         chk(32'(right_loop.enable), 32'(d[7]));
         chk(32'(right_loop.target_hdb), 32'(tgt[i]));
         chk(32'(right_loop.attack_ms), 32'(atk[d[3:2]]));
         chk(32'(right_loop.decay_ms), 32'(dcy[d[1:0]]));
      end
      for (int i = 0; i < 5; i++) begin
         c = mg[i];
         apb(1'b1, adr[2], {c, 1'b0});
         apb(1'b0, adr[2], 8'h00);
         chk(rd, {24'h0, c, 1'b0});
         chk(32'(right_loop.max_gain_hdb), 32'((c > 7'h77) ? 7'h77 : c));
      end
      double_rate <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk(32'(right_loop.times_exact), 32'h0);
      double_rate <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(32'(right_loop.times_exact), 32'h1);
      $display("test right loop done");
      left_max_code <= 7'h10;
      for (int i = 0; i < 3; i++) begin
         pulse(gin[i]);
         apb(1'b0, adr[4], 8'h00);
         chk(rd, {24'h0, gex[i]});
         chk(32'(left_gain), 32'(gex[i]));
      end
      left_max_code <= 7'h7f;
      pulse(8'h77);
      apb(1'b0, adr[4], 8'h00);
      chk(rd, 32'h77);
      left_max_code <= 7'h20;
      apb(1'b1, adr[4], 8'h55);
      chk(32'(err), 32'h0);
      apb(1'b0, adr[4], 8'h00);
      chk(rd, 32'h20);
      apb(1'b0, 12'h084, 8'h00);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, 12'h071, 8'hff);
      chk(32'(err), 32'h1);
      ce <= 1'b0;
      pulse(8'h05);
      chk(32'(left_gain), 32'h20);
      ce <= 1'b1;
      pstrb <= 4'he;
      apb(1'b1, adr[3], 8'h5a);
      pstrb <= 4'hf;
      apb(1'b0, adr[3], 8'h00);
      chk(rd, 32'hc1);
      $display("test applied gain done");
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      apb(1'b0, adr[1], 8'h00);
      chk(rd, 32'h0);
      chk(32'(right_loop.enable), 32'h0);
      apb(1'b0, adr[4], 8'h00);
      chk(rd, 32'h0);
      $display("test mid-run reset done");
      give_verdict();
   end
endmodule // sagc_regs_tb
`default_nettype wire
